// ==== flash_status_pkg.sv ====
package flash_status_pkg;
  // bus geometry
  localparam int ADDR_W = 22;
  localparam int DATA_W = 8;
  // data line bit positions
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int FAIL_BIT = 5;
  localparam int WINDOW_BIT = 3;
  localparam int SEC_TOGGLE_BIT = 2;
  // command values
  localparam logic [7:0] CMD_RESET = 8'hF0;
  // clock rate and bus cycle timing
  localparam int CLK_HZ = 20000000;
  localparam int CYCLE_NS = 100;
  localparam int CYCLE_CLKS = (CYCLE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [3:0] CYCLE_CNT = 4'(CYCLE_CLKS);
  // end of poll result codes
  localparam logic [1:0] RES_DONE = 2'h0;
  localparam logic [1:0] RES_FAIL = 2'h1;
  localparam logic [1:0] RES_SUSPENDED = 2'h2;
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_ACTIVE,
    BUS_RECOVER
  } bus_state_t;
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_WRITE,
    ST_READ_A,
    ST_READ_B,
    ST_CHECK,
    ST_FAIL_READ,
    ST_RECHECK,
    ST_RESET_CMD,
    ST_DONE
  } poll_state_t;
endpackage

// ==== flash_cycle_if.sv ====
`timescale 1ns/1ps
interface flash_cycle_if;
  import flash_status_pkg::*;
  logic req;
  logic wr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic done;
  modport master (output req, output wr, output addr, output wdata, input rdata, input done);
  modport engine (input req, input wr, input addr, input wdata, output rdata, output done);
endinterface

// ==== flash_bus_cycle.sv ====
`timescale 1ns/1ps
module flash_bus_cycle
  import flash_status_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  flash_cycle_if.engine cyc,
  // pins
  output logic [ADDR_W-1:0] addr_q_out,
  output logic [DATA_W-1:0] data_o_out,
  output logic data_oe_out,
  input wire logic [DATA_W-1:0] data_sync_in,
  output logic ce_n_out,
  output logic oe_n_out,
  output logic we_n_out
);
  bus_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [ADDR_W-1:0] a_q, a_d;
  logic [DATA_W-1:0] wd_q, wd_d, rd_q, rd_d;
  logic wr_q, wr_d, ce_q, ce_d, oe_q, oe_d, we_q, we_d, den_q, den_d, done_q, done_d;

  // ----------------------------------------
  // one strobe per cycle, ce and oe both released after every read
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    a_d = a_q;
    wd_d = wd_q;
    rd_d = rd_q;
    wr_d = wr_q;
    ce_d = ce_q;
    oe_d = oe_q;
    we_d = we_q;
    den_d = den_q;
    done_d = 1'b0;
    case (st_q)
      BUS_IDLE: begin
        if (cyc.req) begin
          a_d = cyc.addr;
          wd_d = cyc.wdata;
          wr_d = cyc.wr;
          ce_d = 1'b0;
          oe_d = cyc.wr;
          we_d = !cyc.wr;
          den_d = cyc.wr;
          cnt_d = CYCLE_CNT;
          st_d = BUS_ACTIVE;
        end
      end
      BUS_ACTIVE: begin
        if (cnt_q != 4'h0) begin
          cnt_d = cnt_q - 4'h1;
        end else begin
          rd_d = data_sync_in;
          ce_d = 1'b1;
          oe_d = 1'b1;
          we_d = 1'b1;
          cnt_d = CYCLE_CNT;
          st_d = BUS_RECOVER;
        end
      end
      BUS_RECOVER: begin
        den_d = 1'b0;
        if (cnt_q != 4'h0) begin
          cnt_d = cnt_q - 4'h1;
        end else begin
          done_d = 1'b1;
          st_d = BUS_IDLE;
        end
      end
      default: st_d = BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_q <= BUS_IDLE;
      cnt_q <= 4'h0;
      a_q <= '0;
      wd_q <= '0;
      rd_q <= '0;
      wr_q <= 1'b0;
      ce_q <= 1'b1;
      oe_q <= 1'b1;
      we_q <= 1'b1;
      den_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      a_q <= a_d;
      wd_q <= wd_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      ce_q <= ce_d;
      oe_q <= oe_d;
      we_q <= we_d;
      den_q <= den_d;
      done_q <= done_d;
    end
  end

  assign cyc.rdata = rd_q;
  assign cyc.done = done_q;
  assign addr_q_out = a_q;
  assign data_o_out = wd_q;
  assign data_oe_out = den_q;
  assign ce_n_out = ce_q;
  assign oe_n_out = oe_q;
  assign we_n_out = we_q;
endmodule

// ==== flash_write_status_reporter.sv ====
// Functional notes
// - host reads status at the programmed address
// - host reads erase status inside a selected sector
// - bit 7 may change early; take data on the next read; the sequencer reports the read in which bit 7 matched
// - read cycles may be delimited by output strobe or chip select
// - host reads twice and compares toggle bits; equal means done
// - toggling with fail flag set: recheck, then reset on failure
// - interrupted polling restarts from the first double read; here abort returns to idle and a new start rewrites the command first
// - host rereads status after seeing the fail flag
// - write F0 anywhere returns device to array read
`timescale 1ns/1ps
module flash_write_status_reporter
  import flash_status_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // user command port
  input wire logic start_in,
  input wire logic [ADDR_W-1:0] cmd_addr_in,
  input wire logic [DATA_W-1:0] cmd_data_in,
  input wire logic use_poll_in,
  input wire logic abort_in,
  output logic busy_out,
  output logic done_out,
  output logic [1:0] result_out,
  output logic [DATA_W-1:0] last_status_out,
  output logic ready_level_out,
  // flash pins
  output logic [ADDR_W-1:0] flash_addr_out,
  input wire logic [DATA_W-1:0] flash_data_in,
  output logic [DATA_W-1:0] flash_data_out,
  output logic flash_data_oe_out,
  output logic flash_ce_n_out,
  output logic flash_oe_n_out,
  output logic flash_we_n_out,
  input wire logic ready_busy_n_in
);
  flash_cycle_if cyc ();
  logic [DATA_W-1:0] din_s1_q, din_s2_q;
  logic rb_s1_q, rb_s2_q;
  poll_state_t st_q, st_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] wdat_q, wdat_d, first_q, first_d, stat_q, stat_d;
  logic poll_q, poll_d, req_q, req_d, wr_q, wr_d, done_q, done_d, busy_q, busy_d;
  logic [1:0] res_q, res_d;
  logic [ADDR_W-1:0] cyc_addr_q, cyc_addr_d;
  logic [DATA_W-1:0] cyc_wd_q, cyc_wd_d;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      din_s1_q <= '0;
      din_s2_q <= '0;
      rb_s1_q <= 1'b1;
      rb_s2_q <= 1'b1;
    end else begin
      din_s1_q <= flash_data_in;
      din_s2_q <= din_s1_q;
      rb_s1_q <= ready_busy_n_in;
      rb_s2_q <= rb_s1_q;
    end
  end

  flash_bus_cycle u_cycle (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .cyc(cyc.engine),
    .addr_q_out(flash_addr_out),
    .data_o_out(flash_data_out),
    .data_oe_out(flash_data_oe_out),
    .data_sync_in(din_s2_q),
    .ce_n_out(flash_ce_n_out),
    .oe_n_out(flash_oe_n_out),
    .we_n_out(flash_we_n_out)
  );
  assign cyc.req = req_q;
  assign cyc.wr = wr_q;
  assign cyc.addr = cyc_addr_q;
  assign cyc.wdata = cyc_wd_q;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic toggles(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
    toggles = (a[TOGGLE_BIT] != b[TOGGLE_BIT]);
  endfunction

  function automatic logic poll_true(input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] t);
    poll_true = (s[POLL_BIT] == t[POLL_BIT]);
  endfunction

  // ----------------------------------------
  // completion sequencer
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    addr_d = addr_q;
    wdat_d = wdat_q;
    first_d = first_q;
    stat_d = stat_q;
    poll_d = poll_q;
    req_d = 1'b0;
    wr_d = wr_q;
    cyc_addr_d = cyc_addr_q;
    cyc_wd_d = cyc_wd_q;
    done_d = 1'b0;
    busy_d = busy_q;
    res_d = res_q;
    case (st_q)
      ST_IDLE: begin
        if (start_in) begin
          addr_d = cmd_addr_in;
          wdat_d = cmd_data_in;
          poll_d = use_poll_in;
          busy_d = 1'b1;
          // the final write strobe; status reads follow its rising edge
          req_d = 1'b1;
          wr_d = 1'b1;
          cyc_addr_d = cmd_addr_in;
          cyc_wd_d = cmd_data_in;
          st_d = ST_WRITE;
        end
      end
      ST_WRITE: begin
        if (cyc.done) begin
          // status reads go to the programmed or erased location
          req_d = 1'b1;
          wr_d = 1'b0;
          cyc_addr_d = addr_q;
          st_d = ST_READ_A;
        end
      end
      ST_READ_A: begin
        if (cyc.done) begin
          first_d = cyc.rdata;
          req_d = 1'b1;
          st_d = ST_READ_B;
        end
      end
      ST_READ_B: begin
        if (cyc.done) begin
          stat_d = cyc.rdata;
          st_d = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (abort_in) begin
          // a later start issues the write cycle again before the double read
          busy_d = 1'b0;
          st_d = ST_IDLE;
        end else if (poll_q ? poll_true(stat_q, wdat_q) : !toggles(first_q, stat_q)) begin
          // bit 6 held while bit 2 toggles with ready high: erase suspended, not done
          if (!poll_q && stat_q[SEC_TOGGLE_BIT] != first_q[SEC_TOGGLE_BIT]
              && first_q[POLL_BIT] && stat_q[POLL_BIT] && rb_s2_q) begin
            res_d = RES_SUSPENDED;
          end else begin
            res_d = RES_DONE;
          end
          st_d = ST_DONE;
        end else if (stat_q[FAIL_BIT]) begin
          first_d = stat_q;
          req_d = 1'b1;
          st_d = ST_FAIL_READ;
        end else begin
          first_d = stat_q;
          req_d = 1'b1;
          st_d = ST_READ_B;
        end
      end
      ST_FAIL_READ: begin
        if (cyc.done) begin
          stat_d = cyc.rdata;
          st_d = ST_RECHECK;
        end
      end
      ST_RECHECK: begin
        if (poll_q ? poll_true(stat_q, wdat_q) : !toggles(first_q, stat_q)) begin
          res_d = RES_DONE;
          st_d = ST_DONE;
        end else begin
          req_d = 1'b1;
          wr_d = 1'b1;
          cyc_wd_d = CMD_RESET;
          res_d = RES_FAIL;
          st_d = ST_RESET_CMD;
        end
      end
      ST_RESET_CMD: begin
        if (cyc.done) begin
          st_d = ST_DONE;
        end
      end
      ST_DONE: begin
        // valid array data only from the following read cycle
        done_d = 1'b1;
        busy_d = 1'b0;
        st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_q <= ST_IDLE;
      addr_q <= '0;
      wdat_q <= '0;
      first_q <= '0;
      stat_q <= '0;
      poll_q <= 1'b0;
      req_q <= 1'b0;
      wr_q <= 1'b0;
      cyc_addr_q <= '0;
      cyc_wd_q <= '0;
      done_q <= 1'b0;
      busy_q <= 1'b0;
      res_q <= RES_DONE;
    end else begin
      st_q <= st_d;
      addr_q <= addr_d;
      wdat_q <= wdat_d;
      first_q <= first_d;
      stat_q <= stat_d;
      poll_q <= poll_d;
      req_q <= req_d;
      wr_q <= wr_d;
      cyc_addr_q <= cyc_addr_d;
      cyc_wd_q <= cyc_wd_d;
      done_q <= done_d;
      busy_q <= busy_d;
      res_q <= res_d;
    end
  end

  assign busy_out = busy_q;
  assign done_out = done_q;
  assign result_out = res_q;
  assign last_status_out = stat_q;
  assign ready_level_out = rb_s2_q;
endmodule

// ==== flash_write_status_reporter_properties.sv ====
`timescale 1ns/1ps
module status_checker
  import flash_status_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // watched ports
  input wire logic start_in,
  input wire logic [ADDR_W-1:0] cmd_addr_in,
  input wire logic busy_out,
  input wire logic done_out,
  input wire logic [1:0] result_out,
  input wire logic [ADDR_W-1:0] flash_addr_out,
  input wire logic [DATA_W-1:0] flash_data_out,
  input wire logic flash_data_oe_out,
  input wire logic flash_ce_n_out,
  input wire logic flash_oe_n_out,
  input wire logic flash_we_n_out
);
  // ----
  // read and write counts since the accepted start
  // ----
  logic [ADDR_W-1:0] addr_q;
  logic [3:0] rd_q;
  logic [3:0] wr_q;
  logic oe_n_q;
  logic we_n_q;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      addr_q <= '0;
      rd_q <= 4'h0;
      wr_q <= 4'h0;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
    end else begin
      oe_n_q <= flash_oe_n_out;
      we_n_q <= flash_we_n_out;
      if (start_in && !busy_out) begin
        addr_q <= cmd_addr_in;
        rd_q <= 4'h0;
        wr_q <= 4'h0;
      end else begin
        if (flash_oe_n_out && !oe_n_q && rd_q != 4'hF) rd_q <= rd_q + 4'h1;
        if (flash_we_n_out && !we_n_q && wr_q != 4'hF) wr_q <= wr_q + 4'h1;
      end
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  read_addr_a: assert property (!flash_oe_n_out && busy_out |-> flash_addr_out == addr_q)
    else $error("status read away from command address");
  read_hold_a: assert property (!flash_oe_n_out && !oe_n_q |-> $stable(flash_addr_out))
    else $error("address moved inside read");
  no_drive_a: assert property (!flash_oe_n_out |-> !flash_data_oe_out)
    else $error("data driven during read");
  done_pulse_a: assert property (done_out |=> !done_out)
    else $error("done longer than one cycle");
  two_reads_a: assert property (done_out |-> rd_q >= 4'h2)
    else $error("done before two reads");
  fail_reread_a: assert property (done_out && result_out == RES_FAIL |-> rd_q >= 4'h3)
    else $error("fail without reread");
  fail_reset_a: assert property (done_out && result_out == RES_FAIL |-> wr_q == 4'h2)
    else $error("fail without reset write");
  reset_cmd_a: assert property ($fell(flash_we_n_out) && wr_q == 4'h1 |-> flash_data_out == CMD_RESET)
    else $error("second write is not reset");
  ok_write_a: assert property (done_out && result_out == RES_DONE |-> wr_q == 4'h1)
    else $error("extra write on success");
  strobe_select_a: assert property (!flash_oe_n_out || !flash_we_n_out |-> !flash_ce_n_out)
    else $error("strobe without chip select");
  one_strobe_a: assert property (flash_oe_n_out || flash_we_n_out)
    else $error("read and write strobes low together");
  suspend_write_a: assert property (done_out && result_out == RES_SUSPENDED |-> wr_q == 4'h1)
    else $error("extra write on suspend");
endmodule
bind flash_write_status_reporter status_checker u_chk (.*);

// ==== flash_dev_model.sv ====
`timescale 1ns/1ps
module flash_dev_model (
  // bus pins
  input wire logic [7:0] wdata_in,
  input wire logic ce_n_in,
  input wire logic oe_n_in,
  input wire logic we_n_in,
  // 0 program, 1 erase, 2 failing program, 3 protected target
  input wire logic [1:0] mode_in,
  input wire logic [7:0] busy_reads_in,
  input wire logic suspend_in,
  // status
  output logic [7:0] dq_out,
  output logic rb_drive_low_out
);
  logic busy = 1'b0;
  logic fail = 1'b0;
  logic tog = 1'b0;
  logic sec = 1'b0;
  logic wsel = 1'b0;
  logic [7:0] pd = 8'h00;
  int left = 0;
  initial dq_out = 8'h00;
  // a suspended erase releases the pin
  assign rb_drive_low_out = busy && !suspend_in;
  // select and write strobe rise together, so select is taken while the strobe is low
  always @(negedge we_n_in) #1 wsel = !ce_n_in;
  always @(posedge we_n_in) begin
    if (wsel && wdata_in == 8'hF0 && fail) begin
      busy = 1'b0;
      fail = 1'b0;
    end else if (wsel && !busy) begin
      // a protected target shows busy status, then the old array data
      pd = mode_in == 2'h1 ? 8'hFF : (mode_in == 2'h3 ? pd : wdata_in);
      busy = 1'b1;
      fail = mode_in == 2'h2;
      left = busy_reads_in;
    end
  end
  always @(negedge oe_n_in) begin
    if (busy && suspend_in && mode_in == 2'h1) begin
      // bit 6 holds while bit 2 keeps toggling
      sec = ~sec;
      dq_out = {1'b1, tog, 1'b0, 1'b0, 1'b1, sec, 2'b00};
    end else if (busy) begin
      tog = ~tog;
      if (mode_in == 2'h1) sec = ~sec;
      dq_out = {mode_in == 2'h1 ? 1'b0 : ~pd[7], tog, fail, 1'b0, mode_in == 2'h1, sec, 2'b00};
      left--;
      if (left <= 0 && !fail) busy = 1'b0;
    end else begin
      dq_out = pd;
    end
  end
  // released bus shows the inverse of the last value
  always @(posedge oe_n_in) dq_out = ~dq_out;
endmodule

// ==== flash_write_status_reporter_tb.sv ====
`timescale 1ns/1ps
module flash_write_status_reporter_tb;
  import flash_status_pkg::*;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic start_in = 1'b0;
  logic [ADDR_W-1:0] cmd_addr_in = '0;
  logic [7:0] cmd_data_in = 8'h00;
  logic use_poll_in = 1'b0;
  logic abort_in = 1'b0;
  logic [1:0] dev_mode = 2'h0;
  logic [7:0] dev_reads = 8'h01;
  logic dev_suspend = 1'b0;
  logic [7:0] arr = 8'h00;
  logic busy_out, done_out, ready_level_out, rb_low, ready_busy_n_in;
  logic [1:0] result_out;
  logic [7:0] last_status_out, flash_data_out, flash_data_in;
  logic [ADDR_W-1:0] flash_addr_out;
  logic flash_data_oe_out, flash_ce_n_out, flash_oe_n_out, flash_we_n_out;
  logic [1:0] exp_q[$];
  int err_total = 0;
  int compares = 0;
  int cycles = 0;
  always #25 clk_in = ~clk_in;
  // open-drain pin with pull-up
  assign ready_busy_n_in = rb_low ? 1'b0 : 1'b1;
  flash_write_status_reporter u_flash_write_status_reporter (.clk_in(clk_in),
    .resetn_in(resetn_in), .start_in(start_in), .cmd_addr_in(cmd_addr_in),
    .cmd_data_in(cmd_data_in), .use_poll_in(use_poll_in), .abort_in(abort_in),
    .busy_out(busy_out), .done_out(done_out), .result_out(result_out),
    .last_status_out(last_status_out), .ready_level_out(ready_level_out),
    .flash_addr_out(flash_addr_out), .flash_data_in(flash_data_in),
    .flash_data_out(flash_data_out), .flash_data_oe_out(flash_data_oe_out),
    .flash_ce_n_out(flash_ce_n_out), .flash_oe_n_out(flash_oe_n_out),
    .flash_we_n_out(flash_we_n_out), .ready_busy_n_in(ready_busy_n_in));
  flash_dev_model u_dev (.wdata_in(flash_data_out), .ce_n_in(flash_ce_n_out),
    .oe_n_in(flash_oe_n_out), .we_n_in(flash_we_n_out), .mode_in(dev_mode),
    .busy_reads_in(dev_reads), .suspend_in(dev_suspend), .dq_out(flash_data_in),
    .rb_drive_low_out(rb_low));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("counts: %0d compares, %0d mismatches", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 40000) begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic run(input int mode, input int poll);
    logic [7:0] d;
    int n;
    d = 8'($urandom);
    if (mode == 1 || mode == 4) d[7] = 1'b1;
    exp_q.push_back(mode == 2 ? RES_FAIL : (mode == 4 ? RES_SUSPENDED : RES_DONE));
    // array contents after the command; a protected target keeps them
    if (mode == 1 || mode == 4) arr = 8'hFF;
    else if (mode != 3) arr = d;
    @(posedge clk_in);
    dev_mode <= (mode == 4) ? 2'h1 : 2'(mode);
    dev_suspend <= (mode == 4);
    dev_reads <= 8'($urandom_range(1, 4));
    cmd_data_in <= d;
    cmd_addr_in <= ADDR_W'($urandom);
    use_poll_in <= poll[0];
    start_in <= 1'b1;
    @(posedge clk_in);
    start_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    // second start while busy must be ignored
    cmd_data_in <= ~d;
    start_in <= 1'b1;
    @(posedge clk_in);
    start_in <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_in);
      #1;
      n++;
    end while (done_out !== 1'b1 && n < 3000);
    check({6'h0, result_out}, {6'h0, exp_q.pop_front()});
    if (mode == 2) check({7'h0, last_status_out[FAIL_BIT]}, 8'h01);
    else if (mode == 4) check({7'h0, last_status_out[POLL_BIT]}, 8'h01);
    else check(last_status_out, arr);
    repeat (4) @(posedge clk_in);
    #1;
    check({7'h0, ready_level_out}, 8'h01);
    $display("test mode %0d poll %0d finished", mode, poll);
  endtask
  initial begin
    int n;
    int seen;
    void'($urandom(32'hF36A));
    repeat (12) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    for (int m = 0; m < 3; m++) begin
      for (int p = 0; p < 2; p++) begin
        run(m, p);
      end
    end
    // protected target, then a suspended erase; both use toggle polling
    run(3, 0);
    run(4, 0);
    // abandon a long program
    @(posedge clk_in);
    dev_suspend <= 1'b0;
    dev_mode <= 2'h0;
    dev_reads <= 8'hC8;
    use_poll_in <= 1'b0;
    abort_in <= 1'b1;
    start_in <= 1'b1;
    @(posedge clk_in);
    start_in <= 1'b0;
    n = 0;
    seen = 0;
    do begin
      @(posedge clk_in);
      #1;
      n++;
      if (done_out === 1'b1) seen++;
    end while (busy_out !== 1'b0 && n < 500);
    check({7'h0, busy_out}, 8'h00);
    check(8'(seen), 8'h00);
    $display("test abort finished");
    tally_and_finish();
  end
endmodule
